/* File: logic/rcl_regs.sv */
// Radio configuration and listen duty-cycle register bank on classic Wishbone
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "rcl_consts.svh"
module rcl_regs #(
  parameter int unsigned RES_A_CYC = `RCL_RES_A_CYC,
  parameter int unsigned RES_B_CYC = `RCL_RES_B_CYC,
  parameter int unsigned RES_C_CYC = `RCL_RES_C_CYC,
  parameter int          CAL_CYC   = `RCL_CAL_CYC,
  parameter logic [3:0]  REV_FULL  = 4'h1,  // Arbitrary value
  parameter logic [3:0]  REV_METAL = 4'h0   // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        strength_threshold,
  input  wire logic        sync_match,
  input  wire logic        payload_complete,
  input  wire logic        rx_timeout,
  output logic      [15:0] rate_divisor,
  output logic      [13:0] freq_deviation,
  output logic      [23:0] carrier_freq,
  output logic             low_index_afc_enable,
  output logic      [2:0]  chip_mode,
  output logic             rc_cal_busy,
  output logic             listen_rx_window,
  output logic             fifo_discard,
  output wire logic        irq
);
  logic [15:0] cal_age_q;

  logic [7:0]  br_high_q;
  logic [7:0]  br_low_q;
  logic [5:0]  fdev_high_q;
  logic [7:0]  fdev_low_q;
  logic [7:0]  frf_high_q;
  logic [7:0]  frf_mid_q;
  logic [7:0]  frf_low_q;
  logic        afc_lowb_q;
  logic [1:0]  idle_res_q;
  logic [1:0]  rx_res_q;
  logic        crit_q;
  logic [1:0]  end_q;
  logic [7:0]  idle_coeff_q;
  logic [7:0]  rx_coeff_q;
  logic [2:0]  mode_q;
  logic        listen_en_q;
  logic [15:0] cal_cnt_q;
  logic        discard_pend_q;
  logic [`RCL_IRQ_W-1:0] irq_stat_q;
  logic [`RCL_IRQ_W-1:0] irq_mask_q;
  rcl_pkg::rcl_listen_state_t state_q;
  rcl_pkg::rcl_listen_state_t state_d;
  logic        idle_start;
  logic        rx_start;
  logic        accept_ev;
  logic        halt_ev;
  logic        idle_done;
  logic        rx_done;
  logic [3:0]  pins_sync;

  // Bus decode
  wire  [5:0]  idx     = wb_adr[7:2];
  wire         req     = wb_cyc & wb_stb;
  wire         wr_fire = req & wb_we & wb_ack & wb_sel[0];
  wire  [7:0]  wd      = wb_dat_w[7:0];
  wire         wr_opm  = wr_fire & (idx == `RCL_IDX_OP_MODE);
  wire         wr_cal  = wr_fire & (idx == `RCL_IDX_RC_CAL);
  wire         wr_stat = wr_fire & (idx == `RCL_IDX_IRQ_STAT);
  wire         abort_w = wr_opm & wd[`RCL_OPM_ABORT] & ~wd[`RCL_OPM_LISTEN];
  wire         cal_go  = wr_cal & wd[`RCL_CAL_START] & ~rc_cal_busy;
  wire         cal_fin = rc_cal_busy & (cal_cnt_q == 16'h1);

  wire         strength_s = pins_sync[0];
  wire         sync_s     = pins_sync[1];
  wire         payload_s  = pins_sync[2];
  wire         timeout_s  = pins_sync[3];
  wire         accept     = strength_s & (~crit_q | sync_s);
  wire         rx_finish  = payload_s | timeout_s;

  wire  [7:0]  rd_byte =
    (idx == `RCL_IDX_OP_MODE)   ? {1'b0, listen_en_q, 1'b0, chip_mode, 2'h0} :
    (idx == `RCL_IDX_BR_HIGH)   ? br_high_q :
    (idx == `RCL_IDX_BR_LOW)    ? br_low_q :
    (idx == `RCL_IDX_FDEV_HIGH) ? {2'h0, fdev_high_q} :
    (idx == `RCL_IDX_FDEV_LOW)  ? fdev_low_q :
    (idx == `RCL_IDX_FRF_HIGH)  ? frf_high_q :
    (idx == `RCL_IDX_FRF_MID)   ? frf_mid_q :
    (idx == `RCL_IDX_FRF_LOW)   ? frf_low_q :
    (idx == `RCL_IDX_RC_CAL)    ? {1'b0, ~rc_cal_busy, `RCL_RC_CAL_UNUSED} :
    (idx == `RCL_IDX_AFC)       ? {2'h0, afc_lowb_q, 5'h0} :
    (idx == `RCL_IDX_RSVD_C)    ? `RCL_RST_RSVD_C :
    (idx == `RCL_IDX_LCFG)      ? {idle_res_q, rx_res_q, crit_q, end_q, 1'b0} :
    (idx == `RCL_IDX_LIDLE)     ? idle_coeff_q :
    (idx == `RCL_IDX_LRX)       ? rx_coeff_q :
    (idx == `RCL_IDX_REV)       ? {REV_FULL, REV_METAL} :
    (idx == `RCL_IDX_IRQ_STAT)  ? {5'h0, irq_stat_q} :
    (idx == `RCL_IDX_IRQ_MASK)  ? {5'h0, irq_mask_q} : 8'h00;

  // Derived configuration words
  assign rate_divisor   = {br_high_q, br_low_q};
  assign freq_deviation = {fdev_high_q, fdev_low_q};
  assign carrier_freq   = {frf_high_q, frf_mid_q, frf_low_q};
  assign low_index_afc_enable = afc_lowb_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  rcl_sync3 #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({rx_timeout, payload_complete, sync_match, strength_threshold}),
    .dout (pins_sync)
  );

  // Idle and receive phase timers
  rcl_phase_timer #(
    .RES_A_CYC (RES_A_CYC),
    .RES_B_CYC (RES_B_CYC),
    .RES_C_CYC (RES_C_CYC)
  ) u_idle_timer (
    .clk   (clk),
    .rst   (rst),
    .start (idle_start),
    .coeff (idle_coeff_q),
    .res   (idle_res_q),
    .busy  (),
    .done  (idle_done)
  );

  rcl_phase_timer #(
    .RES_A_CYC (RES_A_CYC),
    .RES_B_CYC (RES_B_CYC),
    .RES_C_CYC (RES_C_CYC)
  ) u_rx_timer (
    .clk   (clk),
    .rst   (rst),
    .start (rx_start),
    .coeff (rx_coeff_q),
    .res   (rx_res_q),
    .busy  (),
    .done  (rx_done)
  );

  // Wishbone answer, one wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack   <= 1'b0;
      wb_dat_r <= 32'h0;
    end else begin
      wb_ack   <= req & ~wb_ack;
      wb_dat_r <= {24'h0, rd_byte};
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      br_high_q    <= `RCL_RST_BR_HIGH;
      br_low_q     <= `RCL_RST_BR_LOW;
      fdev_high_q  <= `RCL_RST_FDEV_HIGH;
      fdev_low_q   <= `RCL_RST_FDEV_LOW;
      frf_high_q   <= `RCL_RST_FRF_HIGH;
      frf_mid_q    <= `RCL_RST_FRF_MID;
      frf_low_q    <= `RCL_RST_FRF_LOW;
      afc_lowb_q   <= 1'b0;
      idle_res_q   <= `RCL_RST_IDLE_RES;
      rx_res_q     <= `RCL_RST_RX_RES;
      crit_q       <= 1'b0;
      end_q        <= `RCL_RST_END;
      idle_coeff_q <= `RCL_RST_LIDLE;
      rx_coeff_q   <= `RCL_RST_LRX;
      mode_q       <= `RCL_RST_MODE;
      listen_en_q  <= 1'b0;
      irq_mask_q   <= '0;
    end else if (wr_fire) begin
      case (idx)
        `RCL_IDX_OP_MODE: begin
          mode_q      <= wd[`RCL_OPM_MODE_HI:`RCL_OPM_MODE_LO];
          listen_en_q <= wd[`RCL_OPM_LISTEN];
        end
        `RCL_IDX_BR_HIGH:   br_high_q <= wd;
        `RCL_IDX_BR_LOW:    br_low_q <= wd;
        `RCL_IDX_FDEV_HIGH: fdev_high_q <= wd[5:0];
        `RCL_IDX_FDEV_LOW:  fdev_low_q <= wd;
        `RCL_IDX_FRF_HIGH:  frf_high_q <= wd;
        `RCL_IDX_FRF_MID:   frf_mid_q <= wd;
        `RCL_IDX_FRF_LOW:   frf_low_q <= wd;
        `RCL_IDX_AFC:       afc_lowb_q <= wd[`RCL_AFC_LOWB];
        `RCL_IDX_LCFG: begin
          idle_res_q <= wd[`RCL_LCFG_IDLE_HI:`RCL_LCFG_IDLE_LO];
          rx_res_q   <= wd[`RCL_LCFG_RX_HI:`RCL_LCFG_RX_LO];
          crit_q     <= wd[`RCL_LCFG_CRIT];
          end_q      <= wd[`RCL_LCFG_END_HI:`RCL_LCFG_END_LO];
        end
        `RCL_IDX_LIDLE:     idle_coeff_q <= wd;
        `RCL_IDX_LRX:       rx_coeff_q <= wd;
        `RCL_IDX_IRQ_MASK:  irq_mask_q <= wd[`RCL_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // RC oscillator calibration sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_cal_busy <= 1'b0;
      cal_cnt_q   <= 16'h0;
    end else if (cal_go) begin
      rc_cal_busy <= 1'b1;
      cal_cnt_q   <= 16'(CAL_CYC);
    end else if (rc_cal_busy) begin
      cal_cnt_q <= cal_cnt_q - 16'h1;
      if (cal_fin) begin
        rc_cal_busy <= 1'b0;
      end
    end
  end

  // Listen duty-cycle sequencer
  always_comb begin
    state_d    = state_q;
    idle_start = 1'b0;
    rx_start   = 1'b0;
    accept_ev  = 1'b0;
    halt_ev    = 1'b0;
    if (abort_w) begin
      state_d = rcl_pkg::ls_off;
    end else begin
      case (state_q)
        rcl_pkg::ls_off: begin
          if (listen_en_q) begin
            state_d    = rcl_pkg::ls_idle;
            idle_start = 1'b1;
          end
        end
        rcl_pkg::ls_idle: begin
          if (idle_done) begin
            state_d  = rcl_pkg::ls_rx;
            rx_start = 1'b1;
          end
        end
        rcl_pkg::ls_rx: begin
          if (accept) begin
            accept_ev = 1'b1;
            if (end_q == `RCL_END_STAY) begin
              state_d = rcl_pkg::ls_keep_rx;
              halt_ev = 1'b1;
            end else begin
              state_d = rcl_pkg::ls_hold;
            end
          end else if (rx_done) begin
            state_d    = rcl_pkg::ls_idle;
            idle_start = 1'b1;
          end
        end
        rcl_pkg::ls_hold: begin
          if (rx_finish) begin
            if (end_q == `RCL_END_RESUME) begin
              state_d    = rcl_pkg::ls_idle;
              idle_start = 1'b1;
            end else begin
              state_d = rcl_pkg::ls_halted;
              halt_ev = 1'b1;
            end
          end
        end
        rcl_pkg::ls_keep_rx, rcl_pkg::ls_halted: begin
          if (!listen_en_q) begin
            state_d = rcl_pkg::ls_off;
          end
        end
        default: state_d = rcl_pkg::ls_off;
      endcase
    end
  end

  wire resume_flush = (state_q == rcl_pkg::ls_hold) & (state_d == rcl_pkg::ls_idle);
  wire in_rx = (state_q == rcl_pkg::ls_rx) | (state_q == rcl_pkg::ls_hold) | (state_q == rcl_pkg::ls_keep_rx);
  wire [`RCL_IRQ_W-1:0] irq_ev = {halt_ev, accept_ev, cal_fin};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q          <= rcl_pkg::ls_off;
      chip_mode        <= `RCL_RST_MODE;
      listen_rx_window <= 1'b0;
      discard_pend_q   <= 1'b0;
      fifo_discard     <= 1'b0;
      irq_stat_q       <= '0;
    end else begin
      state_q          <= state_d;
      chip_mode        <= in_rx ? rcl_pkg::mode_rx : mode_q;
      listen_rx_window <= (state_q == rcl_pkg::ls_rx);
      fifo_discard     <= rx_start & discard_pend_q;
      discard_pend_q   <= (discard_pend_q & ~rx_start) | resume_flush;
      // Set wins over a same-cycle write-one clear
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? wd[`RCL_IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  // Busy-cycle count for the calibration length check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_age_q <= 16'h0;
    end else begin
      cal_age_q <= rc_cal_busy ? cal_age_q + 16'h1 : 16'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cal_launch;
    cal_go ##1 rc_cal_busy;
  endsequence

  AST_ACK_ONE: assert property (wb_ack |=> !wb_ack) else $error("ack held two cycles");
  AST_RATE_LOW: assert property (wr_fire && idx == `RCL_IDX_BR_LOW |=> rate_divisor[7:0] == $past(wd))
    else $error("bit-rate low byte not stored");
  AST_CAL_LOAD: assert property (s_cal_launch |-> cal_cnt_q == 16'(CAL_CYC))
    else $error("calibration length not loaded");
  AST_CAL_RUN: assert property (rc_cal_busy |-> cal_age_q < 16'(CAL_CYC))
    else $error("calibration never finished");
  AST_CAL_READ: assert property (wb_ack && !wb_we && idx == `RCL_IDX_RC_CAL |-> !wb_dat_r[7])
    else $error("calibration start bit read back one");
  AST_ABORT: assert property (abort_w |=> state_q == rcl_pkg::ls_off ##1 !listen_rx_window)
    else $error("abort did not stop listening");
  AST_END_STAY: assert property (state_q == rcl_pkg::ls_rx && accept && end_q == `RCL_END_STAY && !abort_w
    |=> state_q == rcl_pkg::ls_keep_rx ##1 chip_mode == rcl_pkg::mode_rx)
    else $error("end action 00 left receive");
  AST_RESUME_ARM: assert property (resume_flush |=> discard_pend_q)
    else $error("FIFO discard not armed on resume");
  AST_END_RESUME: assert property (rx_start && discard_pend_q |=> fifo_discard)
    else $error("FIFO discard missing at wakeup");
  AST_IDLE_TO_RX: assert property (state_q == rcl_pkg::ls_idle && idle_done && !abort_w
    |=> state_q == rcl_pkg::ls_rx)
    else $error("idle phase end did not start receive");
  AST_SET_WINS: assert property (accept_ev && wr_stat |=> irq_stat_q[`RCL_IRQ_ACCEPT])
    else $error("accept event lost against clear");
endmodule

/* File: logic/rcl_consts.svh */
// Register indices, field positions, reset values and timing of the radio config block
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH

`define RCL_IDX_OP_MODE    6'h01
`define RCL_IDX_BR_HIGH    6'h03
`define RCL_IDX_BR_LOW     6'h04
`define RCL_IDX_FDEV_HIGH  6'h05
`define RCL_IDX_FDEV_LOW   6'h06
`define RCL_IDX_FRF_HIGH   6'h07
`define RCL_IDX_FRF_MID    6'h08
`define RCL_IDX_FRF_LOW    6'h09
`define RCL_IDX_RC_CAL     6'h0A
`define RCL_IDX_AFC        6'h0B
`define RCL_IDX_RSVD_C     6'h0C
`define RCL_IDX_LCFG       6'h0D
`define RCL_IDX_LIDLE      6'h0E
`define RCL_IDX_LRX        6'h0F
`define RCL_IDX_REV        6'h10
`define RCL_IDX_IRQ_STAT   6'h20
`define RCL_IDX_IRQ_MASK   6'h21

`define RCL_RST_MODE       3'h1
`define RCL_RST_BR_HIGH    8'h1A
`define RCL_RST_BR_LOW     8'h0B
`define RCL_RST_FDEV_HIGH  6'h00
`define RCL_RST_FDEV_LOW   8'h52
`define RCL_RST_FRF_HIGH   8'hE4
`define RCL_RST_FRF_MID    8'hC0
`define RCL_RST_FRF_LOW    8'h00
`define RCL_RST_RSVD_C     8'h02
`define RCL_RST_IDLE_RES   2'h2
`define RCL_RST_RX_RES     2'h1
`define RCL_RST_END        2'h1
`define RCL_RST_LIDLE      8'hF5
`define RCL_RST_LRX        8'h20
`define RCL_RC_CAL_UNUSED  6'h01

`define RCL_OPM_LISTEN     6
`define RCL_OPM_ABORT      5
`define RCL_OPM_MODE_HI    4
`define RCL_OPM_MODE_LO    2
`define RCL_CAL_START      7
`define RCL_CAL_DONE       6
`define RCL_AFC_LOWB       5
`define RCL_LCFG_IDLE_HI   7
`define RCL_LCFG_IDLE_LO   6
`define RCL_LCFG_RX_HI     5
`define RCL_LCFG_RX_LO     4
`define RCL_LCFG_CRIT      3
`define RCL_LCFG_END_HI    2
`define RCL_LCFG_END_LO    1

`define RCL_IRQ_CAL        0
`define RCL_IRQ_ACCEPT     1
`define RCL_IRQ_HALT       2
`define RCL_IRQ_W          3

`define RCL_END_STAY       2'h0
`define RCL_END_MODE       2'h1
`define RCL_END_RESUME     2'h2

`define RCL_CLK_MHZ        10
`define RCL_RES_A_US       64
`define RCL_RES_B_US       4100
`define RCL_RES_C_US       262000
`define RCL_CAL_TIME_US    100
`define RCL_RES_A_CYC      (`RCL_RES_A_US * `RCL_CLK_MHZ)
`define RCL_RES_B_CYC      (`RCL_RES_B_US * `RCL_CLK_MHZ)
`define RCL_RES_C_CYC      (`RCL_RES_C_US * `RCL_CLK_MHZ)
`define RCL_CAL_CYC        (`RCL_CAL_TIME_US * `RCL_CLK_MHZ)

`endif

/* File: logic/rcl_pkg.sv */
// Types shared by the radio config block
package rcl_pkg;
  typedef enum logic [2:0] {
    ls_off     = 3'h0,
    ls_idle    = 3'h1,
    ls_rx      = 3'h3,
    ls_hold    = 3'h2,
    ls_keep_rx = 3'h6,
    ls_halted  = 3'h7
  } rcl_listen_state_t;

  typedef enum logic [2:0] {
    mode_sleep   = 3'h0,
    mode_standby = 3'h1,
    mode_synth   = 3'h2,
    mode_tx      = 3'h3,
    mode_rx      = 3'h4
  } rcl_mode_t;
endpackage

/* File: logic/rcl_sync3.sv */
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
module rcl_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (s2_q & s3_q) | (dout & (s2_q | s3_q));
    end
  end
endmodule

/* File: logic/rcl_phase_timer.sv */
// Phase timer: coefficient times selected resolution, done pulse at the end
`timescale 1ns/1ps
module rcl_phase_timer #(
  parameter int unsigned RES_A_CYC = 640,
  parameter int unsigned RES_B_CYC = 41000,
  parameter int unsigned RES_C_CYC = 2620000
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] coeff,
  input  wire logic [1:0] res,
  output logic            busy,
  output logic            done
);
  logic [7:0]  remain_q;
  logic [21:0] pre_q;
  wire  [21:0] period;
  wire         res_end;

  // Reserved resolution 00 runs as the shortest one
  assign period  = (res == 2'h3) ? 22'(RES_C_CYC) : (res == 2'h2) ? 22'(RES_B_CYC) : 22'(RES_A_CYC);
  assign res_end = (pre_q >= period - 22'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain_q <= 8'h0;
      pre_q    <= 22'h0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain_q <= coeff;
        pre_q    <= 22'h0;
        busy     <= 1'b1;
      end else if (busy) begin
        if (remain_q == 8'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (res_end) begin
          pre_q    <= 22'h0;
          remain_q <= remain_q - 8'h1;
        end else begin
          pre_q <= pre_q + 22'h1;
        end
      end
    end
  end
endmodule

/* File: bench/radio_config_listen_regs_test.sv */
// Self-checking testbench of the radio config and listen register bank
`timescale 1ns/1ps
`include "rcl_consts.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module radio_config_listen_regs_test;
  localparam int RA = 4;
  localparam int RB = 8;
  localparam int RC = 16;
  localparam logic [5:0] IX [14] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0B, 6'h0C, 6'h0D,
                                     6'h0E, 6'h0F, 6'h10, 6'h3F};
  localparam logic [7:0] RV [14] = '{8'h1A, 8'h0B, 8'h00, 8'h52, 8'hE4, 8'hC0, 8'h00, 8'h00, 8'h02, 8'h92,
                                     8'hF5, 8'h20, 8'h10, 8'h00};
  localparam logic [7:0] WV [14] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h20, 8'h02, 8'hFE,
                                     8'hFF, 8'hFF, 8'h10, 8'h00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic        strength_threshold = 1'b0;
  logic        sync_match = 1'b0;
  logic        payload_complete = 1'b0;
  logic        rx_timeout = 1'b0;
  logic [15:0] rate_divisor;
  logic [13:0] freq_deviation;
  logic [23:0] carrier_freq;
  logic        low_index_afc_enable;
  logic [2:0]  chip_mode;
  logic        rc_cal_busy;
  logic        listen_rx_window;
  logic        fifo_discard;
  logic        irq;
  int          errors = 0;
  int          n_compared = 0;

  always #50 clk = ~clk;

  rcl_regs #(.RES_A_CYC(RA), .RES_B_CYC(RB), .RES_C_CYC(RC), .CAL_CYC(10)) dut (
    .clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .strength_threshold(strength_threshold), .sync_match(sync_match), .payload_complete(payload_complete),
    .rx_timeout(rx_timeout), .rate_divisor(rate_divisor), .freq_deviation(freq_deviation),
    .carrier_freq(carrier_freq), .low_index_afc_enable(low_index_afc_enable), .chip_mode(chip_mode),
    .rc_cal_busy(rc_cal_busy), .listen_rx_window(listen_rx_window), .fifo_discard(fifo_discard), .irq(irq));

  task test_done;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One classic cycle; held until ack is sampled high
  task wb(input logic we, input logic [5:0] idx, input logic [7:0] d, input logic s0, output logic [7:0] q);
    int n;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'h0};
    wb_sel <= {3'h7, s0};
    wb_dat_w <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_dat_r[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      errors++;
      $display("Error bus ack expected 1 seen 0");
      test_done;
    end
  endtask

  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, 1'b1, q);
  endtask

  task rdc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, 1'b1, q);
    `CHK(nm, exp, q)
  endtask

  // Sel 0 busy low, 1 rx window, 2 discard pulse
  task poll(input int sel, input logic lvl, output int n);
    logic v;
    for (n = 1; n < 3000; n++) begin
      @(posedge clk);
      v = (sel == 0) ? rc_cal_busy : (sel == 1) ? listen_rx_window : fifo_discard;
      if (v === lvl) return;
    end
    errors++;
    $display("Error wait expected %0d seen timeout", sel);
    test_done;
  endtask

  function automatic int res_cyc(input logic [1:0] r);
    return (r == 2'h3) ? RC : (r == 2'h2) ? RB : RA;
  endfunction

  task t_regs;
    logic [7:0] q;
    `CHK("rate_divisor", 16'h1A0B, rate_divisor)
    `CHK("freq_deviation", 14'h0052, freq_deviation)
    `CHK("carrier_freq", 24'hE4C000, carrier_freq)
    `CHK("chip_mode", 3'h1, chip_mode)
    for (int i = 0; i < 14; i++) rdc("reset value", IX[i], RV[i]);
    rdc("calibration", `RCL_IDX_RC_CAL, 8'h41);
    rdc("op mode", `RCL_IDX_OP_MODE, 8'h04);
    for (int i = 0; i < 14; i++) begin
      wr(IX[i], 8'hFF);
      rdc("readback", IX[i], WV[i]);
    end
    `CHK("rate_divisor", 16'hFFFF, rate_divisor)
    `CHK("freq_deviation", 14'h3FFF, freq_deviation)
    `CHK("carrier_freq", 24'hFFFFFF, carrier_freq)
    `CHK("afc", 1'b1, low_index_afc_enable)
    wb(1'b1, `RCL_IDX_BR_LOW, 8'h00, 1'b0, q);
    rdc("sel gated", `RCL_IDX_BR_LOW, 8'hFF);
  endtask

  task t_cal;
    int n;
    wr(`RCL_IDX_IRQ_STAT, 8'h07);
    wr(`RCL_IDX_RC_CAL, 8'h80);
    rdc("cal running", `RCL_IDX_RC_CAL, 8'h01);
    `CHK("cal busy", 1'b1, rc_cal_busy)
    poll(0, 1'b0, n);
    rdc("cal done", `RCL_IDX_RC_CAL, 8'h41);
    rdc("status", `RCL_IDX_IRQ_STAT, 8'h01);
    `CHK("irq masked", 1'b0, irq)
    wr(`RCL_IDX_IRQ_MASK, 8'h01);
    @(posedge clk);
    `CHK("irq", 1'b1, irq)
    wr(`RCL_IDX_IRQ_STAT, 8'h01);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
  endtask

  task t_timing(input logic [1:0] r);
    int n;
    wr(`RCL_IDX_LCFG, {r, r, 1'b0, 2'h0, 1'b0});
    wr(`RCL_IDX_LIDLE, 8'h03);
    wr(`RCL_IDX_LRX, 8'h05);
    wr(`RCL_IDX_OP_MODE, 8'h44);
    poll(1, 1'b1, n);
    `CHK("idle length", 1'b1, n >= 3 * res_cyc(r) && n <= 3 * res_cyc(r) + 5)
    poll(1, 1'b0, n);
    `CHK("rx length", 1'b1, n >= 5 * res_cyc(r) - 1 && n <= 5 * res_cyc(r) + 3)
    poll(1, 1'b1, n);
    `CHK("idle again", 1'b1, n >= 3 * res_cyc(r) - 1 && n <= 3 * res_cyc(r) + 5)
    wr(`RCL_IDX_OP_MODE, 8'h24);
    repeat (3) @(posedge clk);
    `CHK("aborted", 1'b0, listen_rx_window)
    rdc("abort reads zero", `RCL_IDX_OP_MODE, 8'h04);
  endtask

  task t_accept(input logic [1:0] ea, input logic crit);
    int n;
    logic [7:0] q;
    wr(`RCL_IDX_IRQ_STAT, 8'h07);
    wr(`RCL_IDX_LCFG, {2'h1, 2'h1, crit, ea, 1'b0});
    wr(`RCL_IDX_LRX, 8'h14);
    wr(`RCL_IDX_OP_MODE, 8'h44);
    poll(1, 1'b1, n);
    `CHK("rx mode", 3'h4, chip_mode)
    strength_threshold <= 1'b1;
    if (crit) begin
      repeat (8) @(posedge clk);
      rdc("no sync", `RCL_IDX_IRQ_STAT, 8'h00);
      sync_match <= 1'b1;
    end
    repeat (8) @(posedge clk);
    strength_threshold <= 1'b0;
    sync_match <= 1'b0;
    wb(1'b0, `RCL_IDX_IRQ_STAT, 8'h00, 1'b1, q);
    `CHK("accepted", 1'b1, q[1])
    if (ea == 2'h0) begin
      wb(1'b0, `RCL_IDX_IRQ_STAT, 8'h00, 1'b1, q);
      `CHK("halted", 1'b1, q[2])
      `CHK("stays rx", 3'h4, chip_mode)
    end else if (ea == 2'h1) begin
      `CHK("waits rx", 3'h4, chip_mode)
      payload_complete <= 1'b1;
      repeat (8) @(posedge clk);
      payload_complete <= 1'b0;
      `CHK("stored mode", 3'h1, chip_mode)
      wb(1'b0, `RCL_IDX_IRQ_STAT, 8'h00, 1'b1, q);
      `CHK("halted", 1'b1, q[2])
    end else begin
      rx_timeout <= 1'b1;
      repeat (8) @(posedge clk);
      rx_timeout <= 1'b0;
      poll(2, 1'b1, n);
      @(posedge clk);
      `CHK("discard pulse", 1'b0, fifo_discard)
      `CHK("discard", 1'b1, listen_rx_window)
    end
    wr(`RCL_IDX_OP_MODE, 8'h24);
    repeat (3) @(posedge clk);
    `CHK("aborted", 1'b0, listen_rx_window)
    `CHK("standby", 3'h1, chip_mode)
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_cal;
    for (int r = 1; r < 4; r++) t_timing(r[1:0]);
    wr(`RCL_IDX_LIDLE, 8'h03);
    t_accept(2'h0, 1'b0);
    t_accept(2'h1, 1'b1);
    t_accept(2'h2, 1'b0);
    test_done;
  end
endmodule
